// File: hw/controller_error_logger.sv
// error logging, error flags and task and instruction indicators of the controller
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module controller_error_logger
  import err_log_pkg::*;
#(
  parameter int RECORDS = LOG_RECORDS,
  parameter int TASKS = 32,
  parameter logic [19:0] PARAM_AREA_LO = 20'h00000,
  parameter logic [19:0] PARAM_AREA_HI = 20'h00FFF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // error requests from the execution core
  input wire logic err_valid,
  input wire err_req_s err_req,
  input wire logic [15:0] prog_err_set,
  input wire bcd_time_s now,
  // user program memory access checking
  input wire logic access_valid,
  input wire logic [19:0] access_addr,
  output logic illegal_access,
  // instruction and task sequencing
  input wire logic instr_start,
  input wire logic instr_fail,
  output logic instruction_error_indicator,
  input wire logic task_ready,
  input wire logic task_start,
  input wire logic task_end,
  input wire logic [$clog2(TASKS)-1:0] task_id,
  output logic initial_task_indicator,
  // summary outputs
  output logic fatal_halt,
  output logic memory_error_indicator
);

  localparam int PW = $clog2(RECORDS);
  localparam int IW = $clog2(RECORDS * REC_WORDS);

  function automatic logic in_param_area(input logic [19:0] a);
    in_param_area = (a >= PARAM_AREA_LO) && (a <= PARAM_AREA_HI);
  endfunction : in_param_area

  function automatic logic [15:0] pack_pair(input logic [7:0] hi, input logic [7:0] lo);
    pack_pair = {hi, lo};
  endfunction : pack_pair

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  logic param_hit;
  logic log_en;
  err_req_s log_req;
  logic [15:0] prog_detail_q, prog_detail_d;
  logic [15:0] map_code, map_flag;
  logic map_fatal;
  err_rec_s rec;
  logic [PW-1:0] ptr;
  logic wrapped;
  logic [15:0] log_word;
  logic [IW-1:0] log_index;
  logic log_clear;

  assign param_hit = access_valid && in_param_area(access_addr);

  // an external request takes the log slot; a simultaneous illegal access
  // still sets its flags but is not logged as a second record that cycle
  always_comb begin
    log_en = err_valid || param_hit;
    log_req = err_req;
    if (!err_valid) begin
      log_req.kind = ERR_PROGRAM;
      log_req.arg = '0;
      log_req.unit_special = 1'b0;
      log_req.region = '0;
    end
  end

  // ----------------------------------------------------------------
  // program error detail word
  // ----------------------------------------------------------------
  always_comb begin
    prog_detail_d = prog_detail_q;
    if (reg_wr && reg_addr == REG_PROG_DETAIL) begin
      prog_detail_d = prog_detail_d & ~reg_wdata[15:0];
    end
    prog_detail_d = prog_detail_d | (prog_err_set & PE_VALID_MASK);
    if (param_hit) begin
      prog_detail_d[PE_ILLEGAL_AREA] = 1'b1;
    end
    if (instr_fail) begin
      prog_detail_d[PE_INSTR_PROC] = 1'b1;
    end
  end

  err_code_map u_map (
    .req(log_req),
    .prog_detail(prog_detail_d),
    .code(map_code),
    .flag(map_flag),
    .fatal(map_fatal)
  );

  always_comb begin
    rec.code = map_code;
    rec.detail = map_flag;
    rec.min_sec = pack_pair(now.minute, now.second);
    rec.day_hour = pack_pair(now.day, now.hour);
    rec.year_month = pack_pair(now.year, now.month);
  end

  assign log_clear = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLEAR_LOG];
  assign log_index = IW'((reg_addr - REG_LOG_BASE) >> 2);

  err_record_store #(
    .RECORDS(RECORDS)
  ) u_store (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(log_en),
    .wr_rec(rec),
    .clear(log_clear),
    .rd_index(log_index),
    .rd_word(log_word),
    .ptr(ptr),
    .wrapped(wrapped)
  );

  // ----------------------------------------------------------------
  // flags and indicators
  // ----------------------------------------------------------------
  logic [15:0] dup_flag_q, dup_flag_d;
  logic [15:0] last_code_q, last_code_d;
  logic fatal_q, fatal_d;
  logic mem_err_q, mem_err_d;
  logic illegal_q, illegal_d;
  logic instr_err_q, instr_err_d;
  logic initial_q, initial_d;
  logic [TASKS-1:0] ran_q, ran_d;

  always_comb begin
    dup_flag_d = dup_flag_q;
    last_code_d = last_code_q;
    fatal_d = fatal_q;
    mem_err_d = mem_err_q;
    if (log_en) begin
      last_code_d = map_code;
      fatal_d = fatal_q | map_fatal;
      if (log_req.kind == ERR_DUP_UNIT) begin
        dup_flag_d = map_flag;
      end
      if (log_req.kind == ERR_MEMORY) begin
        mem_err_d = 1'b1;
      end
    end
    // access error flag stands only for the one cycle after the access
    illegal_d = param_hit;
    // cleared when the next instruction starts, but a failure wins
    instr_err_d = instr_err_q;
    if (instr_start) begin
      instr_err_d = 1'b0;
    end
    if (instr_fail) begin
      instr_err_d = 1'b1;
    end
    ran_d = ran_q;
    initial_d = initial_q;
    if (task_end) begin
      initial_d = 1'b0;
    end
    if (task_ready) begin
      ran_d[task_id] = 1'b0;
    end
    if (task_start) begin
      initial_d = !ran_q[task_id];
      ran_d[task_id] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prog_detail_q <= 16'h0000;
      dup_flag_q <= 16'h0000;
      last_code_q <= 16'h0000;
      fatal_q <= 1'b0;
      mem_err_q <= 1'b0;
      illegal_q <= 1'b0;
      instr_err_q <= 1'b0;
      initial_q <= 1'b0;
      ran_q <= '0;
    end else begin
      prog_detail_q <= prog_detail_d;
      dup_flag_q <= dup_flag_d;
      last_code_q <= last_code_d;
      fatal_q <= fatal_d;
      mem_err_q <= mem_err_d;
      illegal_q <= illegal_d;
      instr_err_q <= instr_err_d;
      initial_q <= initial_d;
      ran_q <= ran_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [STATUS_W-1:0] status_q, status_d;
  logic [STATUS_W-1:0] mask_q, mask_d;
  logic [STATUS_W-1:0] events;
  logic irq_q, irq_d;

  always_comb begin
    events = '0;
    events[ST_FATAL] = log_en && map_fatal;
    events[ST_NONFATAL] = log_en && !map_fatal;
    events[ST_ILLEGAL] = param_hit;
    events[ST_INSTR_ERR] = instr_fail;
    events[ST_WRAP] = log_en && !log_clear && (ptr == PW'(RECORDS - 1));
    status_d = status_q;
    mask_d = mask_q;
    if (reg_wr && reg_addr == REG_STATUS) begin
      status_d = status_d & ~reg_wdata[STATUS_W-1:0];
    end
    if (reg_wr && reg_addr == REG_MASK) begin
      mask_d = reg_wdata[STATUS_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    status_d = status_d | events;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_q <= STATUS_RESET;
      mask_q <= MASK_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr >= REG_LOG_BASE && ((reg_addr - REG_LOG_BASE) >> 2) < 10'(RECORDS * REC_WORDS)) begin
        rdata_d = {16'h0000, log_word};
      end else begin
        unique case (reg_addr)
          REG_STATUS: rdata_d = {27'h0000000, status_q};
          REG_MASK: rdata_d = {27'h0000000, mask_q};
          REG_POINTER: rdata_d = {15'h0000, wrapped, 16'(ptr)};
          REG_PROG_DETAIL: rdata_d = {16'h0000, prog_detail_q};
          REG_DUP_FLAG: rdata_d = {16'h0000, dup_flag_q};
          REG_LAST_CODE: rdata_d = {16'h0000, last_code_q};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign illegal_access = illegal_q;
  assign instruction_error_indicator = instr_err_q;
  assign initial_task_indicator = initial_q;
  assign fatal_halt = fatal_q;
  assign memory_error_indicator = mem_err_q;

endmodule : controller_error_logger
`default_nettype wire

// File: hw/err_code_map.sv
// maps an error request to its code, flag word and fatal class
`timescale 1ns/1ns
`default_nettype none
module err_code_map
  import err_log_pkg::*;
(
  input wire err_req_s req,
  input wire logic [15:0] prog_detail,
  output logic [15:0] code,
  output logic [15:0] flag,
  output logic fatal
);

  always_comb begin
    code = FLAG_NONE;
    flag = FLAG_NONE;
    fatal = 1'b1;
    unique case (req.kind)
      ERR_MEMORY: begin
        code = CODE_MEMORY;
        flag = {8'h00, req.region};
      end
      ERR_IO_BUS: code = {CODE_IO_BUS_HI, req.arg[3:0]};
      ERR_DUP_UNIT: begin
        code = CODE_DUP_UNIT;
        flag = {req.unit_special, 7'h00, req.arg[7:0]};
      end
      ERR_TOO_MANY_IO: code = CODE_TOO_MANY_IO;
      ERR_IO_SETTING: code = CODE_IO_SETTING;
      ERR_PROGRAM: begin
        code = CODE_PROGRAM;
        flag = prog_detail;
      end
      ERR_CYCLE_LONG: code = CODE_CYCLE_LONG;
      ERR_DUP_RACK: code = CODE_DUP_RACK;
      ERR_FATAL_ALARM: code = CODE_FATAL_ALARM_BASE + {7'h00, req.arg};
      ERR_NONFATAL_ALARM: begin
        code = CODE_NONFATAL_ALARM_BASE + {7'h00, req.arg};
        fatal = 1'b0;
      end
      ERR_INT_TASK: begin
        code = CODE_INT_TASK;
        fatal = 1'b0;
      end
      ERR_BASIC_IO: begin
        code = CODE_BASIC_IO;
        fatal = 1'b0;
      end
      ERR_SETUP: begin
        code = CODE_SETUP;
        fatal = 1'b0;
      end
      ERR_BATTERY: begin
        code = CODE_BATTERY;
        fatal = 1'b0;
      end
      ERR_BUS_UNIT: begin
        code = {CODE_BUS_UNIT_HI, req.arg[3:0]};
        fatal = 1'b0;
      end
      ERR_SPECIAL: begin
        code = {CODE_SPECIAL_HI, req.arg[7:0]};
        flag = FLAG_NONE;
        fatal = 1'b0;
      end
      ERR_BUS_SETUP: begin
        code = {CODE_BUS_SETUP_HI, req.arg[3:0]};
        fatal = 1'b0;
      end
      ERR_SPECIAL_SETUP: begin
        code = {CODE_SPECIAL_SETUP_HI, req.arg[7:0]};
        flag = FLAG_NONE;
        fatal = 1'b0;
      end
      default: begin
        code = FLAG_NONE;
        flag = FLAG_NONE;
        fatal = 1'b0;
      end
    endcase
  end

endmodule : err_code_map
`default_nettype wire

// File: hw/err_log_pkg.sv
// shared constants, types and register map of the controller error logger
package err_log_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [9:0] REG_STATUS = 10'h000;
  localparam logic [9:0] REG_MASK = 10'h004;
  localparam logic [9:0] REG_POINTER = 10'h008;
  localparam logic [9:0] REG_PROG_DETAIL = 10'h00C;
  localparam logic [9:0] REG_DUP_FLAG = 10'h010;
  localparam logic [9:0] REG_LAST_CODE = 10'h014;
  localparam logic [9:0] REG_CTRL = 10'h018;
  localparam logic [9:0] REG_LOG_BASE = 10'h200;

  localparam int STATUS_W = 5;
  localparam int ST_FATAL = 0;
  localparam int ST_NONFATAL = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_INSTR_ERR = 3;
  localparam int ST_WRAP = 4;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [STATUS_W-1:0] MASK_RESET = 5'h00;
  localparam int CTRL_CLEAR_LOG = 0;

  // ----------------------------------------------------------------
  // log geometry
  // ----------------------------------------------------------------
  localparam int REC_WORDS = 5;
  localparam int LOG_RECORDS = 20;

  // ----------------------------------------------------------------
  // error codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_MEMORY = 16'h80F1;
  localparam logic [11:0] CODE_IO_BUS_HI = 12'h80C;
  localparam logic [15:0] CODE_DUP_UNIT = 16'h80E9;
  localparam logic [15:0] CODE_TOO_MANY_IO = 16'h80E1;
  localparam logic [15:0] CODE_IO_SETTING = 16'h80E0;
  localparam logic [15:0] CODE_PROGRAM = 16'h80F0;
  localparam logic [15:0] CODE_CYCLE_LONG = 16'h809F;
  localparam logic [15:0] CODE_DUP_RACK = 16'h80EA;
  localparam logic [15:0] CODE_FATAL_ALARM_BASE = 16'hC100;
  localparam logic [15:0] CODE_NONFATAL_ALARM_BASE = 16'h4100;
  localparam logic [15:0] CODE_INT_TASK = 16'h008B;
  localparam logic [15:0] CODE_BASIC_IO = 16'h009A;
  localparam logic [15:0] CODE_SETUP = 16'h009B;
  localparam logic [15:0] CODE_BATTERY = 16'h00F7;
  localparam logic [11:0] CODE_BUS_UNIT_HI = 12'h020;
  localparam logic [7:0] CODE_SPECIAL_HI = 8'h03;
  localparam logic [11:0] CODE_BUS_SETUP_HI = 12'h040;
  localparam logic [7:0] CODE_SPECIAL_SETUP_HI = 8'h05;
  localparam logic [7:0] REGION_SETUP = 8'h04;
  localparam logic [15:0] FLAG_NONE = 16'h0000;

  // program error detail word bit positions
  localparam int PE_UM_OVERFLOW = 15;
  localparam int PE_ILLEGAL_INSTR = 14;
  localparam int PE_DIST_OVERFLOW = 13;
  localparam int PE_NO_END = 11;
  localparam int PE_ILLEGAL_AREA = 10;
  localparam int PE_INDIRECT = 9;
  localparam int PE_INSTR_PROC = 8;
  localparam logic [15:0] PE_VALID_MASK = 16'hEF00;

  // duplicate unit flag word layout
  localparam int DUP_TYPE_BIT = 15;
  localparam logic DUP_TYPE_BUS = 1'b0;
  localparam logic DUP_TYPE_SPECIAL = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ERR_MEMORY, ERR_IO_BUS, ERR_DUP_UNIT, ERR_TOO_MANY_IO, ERR_IO_SETTING,
    ERR_PROGRAM, ERR_CYCLE_LONG, ERR_DUP_RACK, ERR_FATAL_ALARM, ERR_NONFATAL_ALARM,
    ERR_INT_TASK, ERR_BASIC_IO, ERR_SETUP, ERR_BATTERY, ERR_BUS_UNIT,
    ERR_SPECIAL, ERR_BUS_SETUP, ERR_SPECIAL_SETUP
  } err_kind_e;

  typedef struct packed {
    err_kind_e kind;
    logic [8:0] arg;
    logic unit_special;
    logic [7:0] region;
  } err_req_s;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } bcd_time_s;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] detail;
    logic [15:0] min_sec;
    logic [15:0] day_hour;
    logic [15:0] year_month;
  } err_rec_s;

endpackage : err_log_pkg

// File: hw/err_record_store.sv
// circular store of five-word error records with a write pointer
`timescale 1ns/1ns
`default_nettype none
module err_record_store
  import err_log_pkg::*;
#(
  parameter int RECORDS = LOG_RECORDS
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire err_rec_s wr_rec,
  input wire logic clear,
  input wire logic [$clog2(RECORDS*REC_WORDS)-1:0] rd_index,
  output logic [15:0] rd_word,
  output logic [$clog2(RECORDS)-1:0] ptr,
  output logic wrapped
);

  localparam int DEPTH = RECORDS * REC_WORDS;
  localparam int PW = $clog2(RECORDS);
  localparam int IW = $clog2(DEPTH);

  logic [15:0] mem_q [DEPTH];
  logic [PW-1:0] ptr_q, ptr_d;
  logic wrapped_q, wrapped_d;
  logic [IW-1:0] base;

  // ----------------------------------------------------------------
  // pointer: advance on write, wrap over the oldest record
  // ----------------------------------------------------------------
  always_comb begin
    ptr_d = ptr_q;
    wrapped_d = wrapped_q;
    if (clear) begin
      ptr_d = '0;
      wrapped_d = 1'b0;
    end else if (wr_en) begin
      if (ptr_q == PW'(RECORDS - 1)) begin
        ptr_d = '0;
        wrapped_d = 1'b1;
      end else begin
        ptr_d = ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ptr_q <= '0;
      wrapped_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      wrapped_q <= wrapped_d;
    end
  end

  // ----------------------------------------------------------------
  // record memory, no reset so it maps to plain ram
  // ----------------------------------------------------------------
  assign base = IW'(ptr_q * REC_WORDS);

  always_ff @(posedge clk_sys) begin
    if (wr_en && !clear) begin
      mem_q[base] <= wr_rec.code;
      mem_q[base + IW'(1)] <= wr_rec.detail;
      mem_q[base + IW'(2)] <= wr_rec.min_sec;
      mem_q[base + IW'(3)] <= wr_rec.day_hour;
      mem_q[base + IW'(4)] <= wr_rec.year_month;
    end
  end

  assign rd_word = (rd_index < IW'(DEPTH)) ? mem_q[rd_index] : 16'h0000;
  assign ptr = ptr_q;
  assign wrapped = wrapped_q;

endmodule : err_record_store
`default_nettype wire

// File: verif/controller_error_logger_sva.sv
// assertion checker on the ports of the controller error logger
`timescale 1ns/1ns
`default_nettype none
module controller_error_logger_sva
  import err_log_pkg::*;
#(
  parameter logic [19:0] PARAM_AREA_LO = 20'h00000,
  parameter logic [19:0] PARAM_AREA_HI = 20'h00FFF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic err_valid,
  input wire err_req_s err_req,
  input wire logic access_valid,
  input wire logic [19:0] access_addr,
  input wire logic illegal_access,
  input wire logic instr_start,
  input wire logic instr_fail,
  input wire logic instruction_error_indicator,
  input wire logic task_start,
  input wire logic task_end,
  input wire logic initial_task_indicator,
  input wire logic fatal_halt,
  input wire logic memory_error_indicator
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  chk_alarm_halt: assert property (err_valid && err_req.kind == ERR_FATAL_ALARM |=> fatal_halt)
    else $error("fatal alarm did not halt");
  chk_fatal_held: assert property (err_valid && err_req.kind == ERR_CYCLE_LONG |=> fatal_halt [*3])
    else $error("fatal system error not held");
  chk_nonfatal_class: assert property (err_valid && err_req.kind == ERR_BATTERY && !fatal_halt |=> !fatal_halt)
    else $error("non-fatal error halted");
  chk_memory_flag: assert property (err_valid && err_req.kind == ERR_MEMORY |=> memory_error_indicator)
    else $error("memory error flag missing");
  chk_illegal_hit: assert property (access_valid && access_addr >= PARAM_AREA_LO && access_addr <= PARAM_AREA_HI
    |=> illegal_access)
    else $error("parameter area access not flagged");
  chk_illegal_cause: assert property (illegal_access |-> $past(access_valid))
    else $error("illegal access flag without access");
  chk_instr_set: assert property (instr_fail |=> instruction_error_indicator)
    else $error("instruction error flag not set");
  chk_instr_clear: assert property (instr_start && !instr_fail |=> !instruction_error_indicator)
    else $error("instruction error flag not cleared");
  chk_init_rise: assert property ($rose(initial_task_indicator) |-> $past(task_start))
    else $error("initial task flag rose without task start");
  chk_init_end: assert property (task_end && !task_start |=> !initial_task_indicator)
    else $error("initial task flag outlived the task");
endmodule : controller_error_logger_sva
bind controller_error_logger controller_error_logger_sva #(
  .PARAM_AREA_LO(PARAM_AREA_LO), .PARAM_AREA_HI(PARAM_AREA_HI)
) i_controller_error_logger_sva (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_valid(err_valid),
  .err_req(err_req), .access_valid(access_valid), .access_addr(access_addr), .illegal_access(illegal_access),
  .instr_start(instr_start), .instr_fail(instr_fail), .instruction_error_indicator(instruction_error_indicator),
  .task_start(task_start), .task_end(task_end), .initial_task_indicator(initial_task_indicator),
  .fatal_halt(fatal_halt), .memory_error_indicator(memory_error_indicator)
);
`default_nettype wire

// File: verif/tb.sv
// self-checking testbench of the controller error logger
`timescale 1ns/1ns
`default_nettype none
module tb;
  import err_log_pkg::*;
  // small log so the wrap is reached quickly
  localparam int NREC = 4;
  typedef struct packed {
    err_kind_e kind; logic [8:0] arg; logic us; logic [7:0] region; logic [15:0] code; logic [15:0] det; logic cd;
  } row_s;
  logic clk_sys, reset_n, reg_wr, reg_rd, irq, err_valid, illegal_access, fatal_halt, memory_error_indicator;
  logic instruction_error_indicator, initial_task_indicator;
  logic access_valid, instr_start, instr_fail, task_ready, task_start, task_end;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] prog_err_set;
  logic [19:0] access_addr;
  logic [4:0] task_id;
  logic [5:0] stb;
  err_req_s err_req;
  bcd_time_s now;
  int fail_count, checked;
  row_s rows [20];
  assign {access_valid, task_end, task_start, task_ready, instr_fail, instr_start} = stb;

  controller_error_logger #(.RECORDS(NREC)) i_controller_error_logger (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .err_valid(err_valid), .err_req(err_req),
    .prog_err_set(prog_err_set), .now(now), .access_valid(access_valid), .access_addr(access_addr),
    .illegal_access(illegal_access), .instr_start(instr_start), .instr_fail(instr_fail),
    .instruction_error_indicator(instruction_error_indicator), .task_ready(task_ready),
    .task_start(task_start), .task_end(task_end), .task_id(task_id),
    .initial_task_indicator(initial_task_indicator), .fatal_halt(fatal_halt),
    .memory_error_indicator(memory_error_indicator)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
  endtask : rd
  task automatic log(input row_s r);
    @(posedge clk_sys);
    err_valid <= 1'b1;
    err_req <= '{r.kind, r.arg, r.us, r.region};
    @(posedge clk_sys);
    err_valid <= 1'b0;
  endtask : log
  task automatic pulse(input logic [5:0] v, input logic [19:0] a);
    @(posedge clk_sys);
    stb <= v;
    access_addr <= a;
    @(posedge clk_sys);
    stb <= 6'h00;
    @(negedge clk_sys);
  endtask : pulse
  function automatic logic [9:0] la(input int n, input int w);
    return REG_LOG_BASE + 10'(4 * ((n % NREC) * 5 + w));
  endfunction : la
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, err_valid, reg_addr, reg_wdata, prog_err_set, access_addr, stb} = '0;
    err_req = '0;
    task_id = 5'h03;
    now = '{8'h98, 8'h04, 8'h01, 8'h17, 8'h10, 8'h30};
    fail_count = 0;
    checked = 0;
    rows = '{'{ERR_MEMORY, 9'h0, 1'h0, 8'h04, 16'h80F1, 16'h0004, 1'h1},
      '{ERR_FATAL_ALARM, 9'h1, 1'h0, 8'h0, 16'hC101, 16'h0, 1'h1},
      '{ERR_FATAL_ALARM, 9'h1FF, 1'h0, 8'h0, 16'hC2FF, 16'h0, 1'h1},
      '{ERR_NONFATAL_ALARM, 9'h1, 1'h0, 8'h0, 16'h4101, 16'h0, 1'h0},
      '{ERR_NONFATAL_ALARM, 9'h1FF, 1'h0, 8'h0, 16'h42FF, 16'h0, 1'h0},
      '{ERR_IO_BUS, 9'hF, 1'h0, 8'h0, 16'h80CF, 16'h0, 1'h0},
      '{ERR_DUP_UNIT, 9'h5F, 1'h1, 8'h0, 16'h80E9, 16'h805F, 1'h1},
      '{ERR_DUP_UNIT, 9'hF, 1'h0, 8'h0, 16'h80E9, 16'h000F, 1'h1},
      '{ERR_TOO_MANY_IO, 9'h0, 1'h0, 8'h0, 16'h80E1, 16'h0, 1'h0},
      '{ERR_IO_SETTING, 9'h0, 1'h0, 8'h0, 16'h80E0, 16'h0, 1'h0},
      '{ERR_CYCLE_LONG, 9'h0, 1'h0, 8'h0, 16'h809F, 16'h0, 1'h0},
      '{ERR_DUP_RACK, 9'h0, 1'h0, 8'h0, 16'h80EA, 16'h0, 1'h0},
      '{ERR_INT_TASK, 9'h0, 1'h0, 8'h0, 16'h008B, 16'h0, 1'h0},
      '{ERR_BASIC_IO, 9'h0, 1'h0, 8'h0, 16'h009A, 16'h0, 1'h0},
      '{ERR_SETUP, 9'h0, 1'h0, 8'h0, 16'h009B, 16'h0, 1'h0},
      '{ERR_BATTERY, 9'h0, 1'h0, 8'h0, 16'h00F7, 16'h0, 1'h0},
      '{ERR_BUS_UNIT, 9'hF, 1'h0, 8'h0, 16'h020F, 16'h0, 1'h0},
      '{ERR_SPECIAL, 9'h5F, 1'h0, 8'h0, 16'h035F, 16'h0, 1'h1},
      '{ERR_BUS_SETUP, 9'h0, 1'h0, 8'h0, 16'h0400, 16'h0, 1'h0},
      '{ERR_SPECIAL_SETUP, 9'h5F, 1'h0, 8'h0, 16'h055F, 16'h0, 1'h1}};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk({26'h0, irq, illegal_access, instruction_error_indicator, initial_task_indicator, fatal_halt,
      memory_error_indicator}, 32'h0);
    rd(REG_POINTER, 32'h0);
    rd(10'h01C, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 20; i++) begin
      log(rows[i]);
      rd(la(i, 0), {16'h0, rows[i].code});
      if (rows[i].cd)
        rd(la(i, 1), {16'h0, rows[i].det});
      rd(la(i, 2), 32'h1030);
      rd(la(i, 3), 32'h0117);
      rd(la(i, 4), 32'h9804);
      rd(REG_POINTER, ((i + 1 >= NREC) ? 32'h0001_0000 : 32'h0) | 32'((i + 1) % NREC));
    end
    chk({30'h0, fatal_halt, memory_error_indicator}, 32'h3);
    rd(REG_DUP_FLAG, 32'h000F);
    $display("code table test done");
    // detail bits set in the logging cycle must land in the record
    @(posedge clk_sys);
    prog_err_set <= 16'hFFFF;
    log('{ERR_PROGRAM, 9'h0, 1'h0, 8'h0, 16'h0, 16'h0, 1'h0});
    prog_err_set <= 16'h0000;
    rd(la(20, 0), 32'h80F0);
    rd(la(20, 1), 32'hEF00);
    rd(REG_PROG_DETAIL, 32'hEF00);
    wr(REG_PROG_DETAIL, 32'hEF00);
    rd(REG_PROG_DETAIL, 32'h0);
    $display("program error test done");
    rd(REG_STATUS, 32'h13);
    chk({31'h0, irq}, 32'h0);
    wr(REG_MASK, 32'h1F);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(REG_STATUS, 32'h1F);
    rd(REG_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    pulse(6'h20, 20'h00010);
    chk({31'h0, illegal_access}, 32'h1);
    rd(REG_LAST_CODE, 32'h80F0);
    rd(REG_PROG_DETAIL, 32'h0400);
    pulse(6'h20, 20'h01000);
    chk({31'h0, illegal_access}, 32'h0);
    pulse(6'h02, 20'h0);
    chk({31'h0, instruction_error_indicator}, 32'h1);
    pulse(6'h01, 20'h0);
    chk({31'h0, instruction_error_indicator}, 32'h0);
    $display("access and instruction test done");
    pulse(6'h04, 20'h0);
    pulse(6'h08, 20'h0);
    chk({31'h0, initial_task_indicator}, 32'h1);
    pulse(6'h10, 20'h0);
    chk({31'h0, initial_task_indicator}, 32'h0);
    pulse(6'h08, 20'h0);
    chk({31'h0, initial_task_indicator}, 32'h0);
    pulse(6'h10, 20'h0);
    $display("task flag test done");
    wr(REG_CTRL, 32'h1);
    rd(REG_POINTER, 32'h0);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk({29'h0, fatal_halt, memory_error_indicator, irq}, 32'h0);
    rd(REG_POINTER, 32'h0);
    log(rows[15]);
    rd(REG_STATUS, 32'h2);
    chk({31'h0, fatal_halt}, 32'h0);
    $display("second reset test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
